/* File: flash_params.svh */
/*
  Constants shared by both ends of the serial flash link: opcodes, status
  bit positions, busy times, reset values and controller register offsets.
  Assumes it is included by its bare name, after which flash_pkg is used.
*/
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

// ----------------------------------------------------------------------
// clock and busy times
// ----------------------------------------------------------------------
`define CLK_KHZ      50000
`define T_SSE_MS     150
`define T_SE_MS      250
`define T_CE_S       1.6
`define T_PP_MS      5.0
`define T_PP_TYP_MS  4.0
`define T_WRSR_MS    5.0

// ----------------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------------
`define ADDR_BITS    18
`define PAGE_BYTES   256

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OP_READ      8'h03
`define OP_FREAD     8'h0B
`define OP_SSE_A     8'hD7
`define OP_SSE_B     8'h20
`define OP_SE        8'hD8
`define OP_CE        8'hC7
`define OP_PP        8'h02
`define OP_WREN      8'h06
`define OP_WRDI      8'h04
`define OP_SLEEP     8'hB9
`define OP_RDSR      8'h05
`define OP_WRSR      8'h01
`define OP_ID1       8'h9F
`define OP_ID2       8'hAB

// ----------------------------------------------------------------------
// status bits and reset values
// ----------------------------------------------------------------------
`define SR_BUSY      0
`define SR_WEN       1
`define SR_BPL       2
`define SR_BPH       3
`define SR_LOCK      7
`define SR_RESET     8'h00
`define PIN_RST      5'h19

// ----------------------------------------------------------------------
// controller registers
// ----------------------------------------------------------------------
`define H_CTRL       4'h0
`define H_TX         4'h4
`define H_RX         4'h8
`define H_STAT       4'hC
`define HC_RESET     3'h7
`define SCK_HALF     8

`endif

/* File: flash_pkg.sv */
/*
  Types shared by both ends of the serial flash link.
  Assumes flash_params.svh is compiled alongside.
*/
package flash_pkg;

  // busy engine job, one-hot
  typedef enum logic [3:0]
  {
    JOB_IDLE  = 4'h1,
    JOB_ERASE = 4'h2,
    JOB_PROG  = 4'h4,
    JOB_WRSR  = 4'h8
  } job_t;

  // controller shifter state, one-hot
  typedef enum logic [2:0]
  {
    H_IDLE = 3'h1,
    H_LOW  = 3'h2,
    H_HIGH = 3'h4
  } hstate_t;

endpackage : flash_pkg

/* File: spi_flash_if.sv */
/*
  Pin bundle between the flash device end and the controller end.
  Assumes a weak pull-up on the data-out wire while the device floats it.
*/
`timescale 1ns/1ps
interface spi_flash_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe_n;
  logic wp_n;
  logic hold_n;
  logic so_line;

  // resolved wire level: pull-up wins while the device does not drive
  assign so_line = so_oe_n ? 1'b1 : so;

  modport flash (input cs_n, sck, si, wp_n, hold_n, output so, so_oe_n);
  modport ctrl  (output cs_n, sck, si, wp_n, hold_n, input so_line);
endinterface : spi_flash_if

/* File: flash_end.sv */
/*
  Serial flash device end: pin sampling, command decode, array, page
  buffer and busy engine.
  Assumes one 50 MHz clock; link pins arrive asynchronously and the link
  clock runs at most a fifth of the system clock rate.
*/
`timescale 1ns/1ps
`include "flash_params.svh"
module flash_end
  import flash_pkg::*;
#(
  parameter int         AW      = `ADDR_BITS,
  parameter int         SSE_CYC = $rtoi(`T_SSE_MS * `CLK_KHZ),
  parameter int         SE_CYC  = $rtoi(`T_SE_MS * `CLK_KHZ),
  parameter int         CE_CYC  = $rtoi(`T_CE_S * `CLK_KHZ * 1000),
  parameter int         PP_CYC  = $rtoi(`T_PP_TYP_MS * `CLK_KHZ),
  parameter int         SR_CYC  = $rtoi(`T_WRSR_MS * `CLK_KHZ),
  parameter logic [7:0] ID_MAKER = 8'h5A, // arbitrary value
  parameter logic [7:0] ID_DEV   = 8'h3C, // arbitrary value
  parameter logic [7:0] ID_ALT   = 8'hC3  // arbitrary value
)(
  // clock and reset
  input wire logic   clk,
  input wire logic   resetn,
  // link pins
  spi_flash_if.flash bus
);

  localparam int         TW      = 27;
  // status reset image, indexed per bit so each flop gets one bit
  localparam logic [7:0] SR_INIT = `SR_RESET;

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (AW < 16 || AW > 24)
  begin : g_bad_aw
    $error("address width out of range");
  end
  if (SSE_CYC < 4096 || SE_CYC < 65536 || CE_CYC < (1 << AW) ||
      PP_CYC < `PAGE_BYTES || SR_CYC < 1 || CE_CYC >= (1 << TW) ||
      PP_CYC > $rtoi(`T_PP_MS * `CLK_KHZ))
  begin : g_bad_cyc
    $error("busy counts cannot cover the erase walk or timer");
  end

  // ----------------------------------------------------------------------
  // pin synchronisers: {hold_n, wp_n, si, sck, cs_n}
  // ----------------------------------------------------------------------
  logic [4:0] sy1_r;
  logic [4:0] sy2_r;
  logic [4:0] sy3_r;
  logic [4:0] stab_r;
  logic [4:0] stabd_r;
  logic [4:0] agree;

  assign agree = ~(sy2_r ^ sy3_r);

  // a level counts only once stages two and three agree
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sy1_r   <= `PIN_RST;
      sy2_r   <= `PIN_RST;
      sy3_r   <= `PIN_RST;
      stab_r  <= `PIN_RST;
      stabd_r <= `PIN_RST;
    end
    else
    begin
      sy1_r   <= {bus.hold_n, bus.wp_n, bus.si, bus.sck, bus.cs_n};
      sy2_r   <= sy1_r;
      sy3_r   <= sy2_r;
      stab_r  <= (sy3_r & agree) | (stab_r & ~agree);
      stabd_r <= stab_r;
    end
  end

  // ----------------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------------
  logic mode3_r;
  logic seen_r;
  logic holding;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  assign holding  = ~stab_r[4];
  assign cs_fall  = ~stab_r[0] & stabd_r[0];
  assign cs_rise  = stab_r[0] & ~stabd_r[0];
  assign sck_rise = ~stab_r[0] & ~holding & stab_r[1] & ~stabd_r[1];
  // in mode 3 the idle-high clock's first fall carries nothing
  assign sck_fall = ~stab_r[0] & ~holding & ~stab_r[1] & stabd_r[1] &
                    (~mode3_r | seen_r);

  // ----------------------------------------------------------------------
  // opcode helpers
  // ----------------------------------------------------------------------
  // byte index at which data (in or out) starts
  function automatic logic [2:0] data_start(input logic [7:0] op);
    case (op)
      `OP_READ: data_start = 3'h4;
      `OP_PP:   data_start = 3'h4;
      `OP_ID2:  data_start = 3'h4;
      `OP_FREAD: data_start = 3'h5;
      `OP_RDSR: data_start = 3'h1;
      `OP_ID1:  data_start = 3'h1;
      default:  data_start = 3'h7;
    endcase
  endfunction : data_start

  function automatic logic is_out(input logic [7:0] op);
    is_out = (op == `OP_READ) || (op == `OP_FREAD) || (op == `OP_RDSR) ||
             (op == `OP_ID1) || (op == `OP_ID2);
  endfunction : is_out

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [7:0]    mem  [1 << AW];
  logic [7:0]    pbuf [`PAGE_BYTES];
  job_t          job_r;
  logic [AW-1:0] ptr_r;
  logic          walk_r;
  logic          busy;

  assign busy = (job_r != JOB_IDLE);

  // ----------------------------------------------------------------------
  // serial and status state
  // ----------------------------------------------------------------------
  logic [2:0]     bit_r, bit_nxt;
  logic [2:0]     byte_r, byte_nxt;
  logic [6:0]     sh_r, sh_nxt;
  logic [7:0]     op_r, op_nxt;
  logic [AW-1:0]  addr_r, addr_nxt;
  logic [AW-1:0]  dptr_r, dptr_nxt;
  logic [7:0]     srd_r, srd_nxt;
  logic [255:0]   pvalid_r, pvalid_nxt;
  logic           so_r, so_nxt;
  logic           oe_n_r, oe_n_nxt;
  logic           mode3_nxt, seen_nxt;
  logic           wen_r, wen_nxt;
  logic           sleep_r, sleep_nxt;
  logic           bpl_r, bpl_nxt;
  logic           bph_r, bph_nxt;
  logic           lock_r, lock_nxt;
  logic [7:0]     rx_byte;
  logic [7:0]     status;
  logic [7:0]     out_byte;
  logic [7:0]     pb_idx;
  logic           pb_we;
  logic           go;
  logic           wrsr_ok;
  job_t           start_job;
  logic [AW-1:0]  start_base;
  logic [AW-1:0]  start_end;
  logic [TW-1:0]  start_cyc;

  assign rx_byte = {sh_r, stab_r[2]};
  assign status  = {lock_r, 3'h0, bph_r, bpl_r, wen_r, busy};
  assign pb_idx  = addr_r[7:0] + dptr_r[7:0];
  assign go      = wen_r & ~busy;
  // the lock only bites while protect is low; write also needs it high
  assign wrsr_ok = go & stab_r[3] & ~(lock_r & ~stab_r[3]);

  // output byte for the current data phase
  always_comb
  begin
    case (op_r)
      `OP_READ:  out_byte = mem[addr_r + dptr_r];
      `OP_FREAD: out_byte = mem[addr_r + dptr_r];
      `OP_RDSR:  out_byte = status;
      `OP_ID1:   out_byte = dptr_r[0] ? ID_DEV : ID_MAKER;
      default:   out_byte = ID_ALT;
    endcase
  end

  // next state of the shifter, decoder and status bits
  always_comb
  begin
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    sh_nxt = sh_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    dptr_nxt = dptr_r;
    srd_nxt = srd_r;
    pvalid_nxt = pvalid_r;
    so_nxt = so_r;
    oe_n_nxt = oe_n_r;
    mode3_nxt = mode3_r;
    seen_nxt = seen_r;
    wen_nxt = wen_r;
    sleep_nxt = sleep_r;
    bpl_nxt = bpl_r;
    bph_nxt = bph_r;
    lock_nxt = lock_r;
    pb_we = 1'b0;
    start_job = JOB_IDLE;
    start_base = '0;
    start_end = '1;
    start_cyc = TW'(CE_CYC);
    // page marks are spent once the program walk has passed the page
    if (job_r == JOB_PROG && !walk_r)
      pvalid_nxt = '0;
    if (cs_fall)
    begin
      bit_nxt = 3'h0;
      byte_nxt = 3'h0;
      dptr_nxt = '0;
      // a status poll during the program walk must not drop its marks
      if (!busy)
        pvalid_nxt = '0;
      seen_nxt = 1'b0;
      mode3_nxt = stab_r[1];
    end
    else if (sck_rise)
    begin
      seen_nxt = 1'b1;
      sh_nxt = rx_byte[6:0];
      bit_nxt = bit_r + 3'h1;
      if (bit_r == 3'h7)
      begin
        if (byte_r == 3'h0)
          op_nxt = rx_byte;
        else if (byte_r < 3'h4)
          addr_nxt = {addr_r[AW-9:0], rx_byte};
        if (byte_r == 3'h1)
          srd_nxt = rx_byte;
        if (op_r == `OP_PP && byte_r >= 3'h4 && !busy && !sleep_r)
        begin
          pb_we = 1'b1;
          pvalid_nxt[pb_idx] = 1'b1;
        end
        if (byte_r != 3'h0 && byte_r >= data_start(op_r))
          dptr_nxt = dptr_r + AW'(1);
        if (byte_r != 3'h7)
          byte_nxt = byte_r + 3'h1;
      end
    end
    if (sck_fall && !sleep_r && is_out(op_r) && byte_r != 3'h0 &&
        byte_r >= data_start(op_r))
    begin
      so_nxt = out_byte[~bit_r];
      oe_n_nxt = 1'b0;
    end
    if (stab_r[0] || holding)
      oe_n_nxt = 1'b1;
    if (cs_rise && bit_r == 3'h0)
    begin
      if (op_r == `OP_ID2 && byte_r == 3'h1)
        sleep_nxt = 1'b0;
      else if (!sleep_r)
      begin
        case (op_r)
          `OP_WREN:  if (byte_r == 3'h1) wen_nxt = 1'b1;
          `OP_WRDI:  if (byte_r == 3'h1) wen_nxt = 1'b0;
          `OP_SLEEP: if (byte_r == 3'h1 && !busy) sleep_nxt = 1'b1;
          `OP_CE:    if (byte_r == 3'h1 && go) start_job = JOB_ERASE;
          `OP_SSE_A, `OP_SSE_B:
            if (byte_r == 3'h4 && go)
            begin
              start_job = JOB_ERASE;
              start_base = {addr_r[AW-1:12], 12'h000};
              start_end = {addr_r[AW-1:12], 12'hFFF};
              start_cyc = TW'(SSE_CYC);
            end
          `OP_SE:
            if (byte_r == 3'h4 && go)
            begin
              start_job = JOB_ERASE;
              start_base = {addr_r[AW-1:16], 16'h0000};
              start_end = {addr_r[AW-1:16], 16'hFFFF};
              start_cyc = TW'(SE_CYC);
            end
          `OP_PP:
            if (byte_r >= 3'h4 && dptr_r != '0 && go)
            begin
              start_job = JOB_PROG;
              start_base = {addr_r[AW-1:8], 8'h00};
              start_end = {addr_r[AW-1:8], 8'hFF};
              start_cyc = TW'(PP_CYC);
            end
          `OP_WRSR:
            if (byte_r == 3'h2 && wrsr_ok)
            begin
              start_job = JOB_WRSR;
              start_cyc = TW'(SR_CYC);
              bpl_nxt = srd_r[`SR_BPL];
              bph_nxt = srd_r[`SR_BPH];
              lock_nxt = srd_r[`SR_LOCK];
            end
          default: ;
        endcase
        if (start_job != JOB_IDLE)
          wen_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bit_r <= 3'h0;
      byte_r <= 3'h0;
      sh_r <= 7'h00;
      op_r <= 8'h00;
      addr_r <= '0;
      dptr_r <= '0;
      srd_r <= 8'h00;
      pvalid_r <= '0;
      so_r <= 1'b0;
      oe_n_r <= 1'b1;
      mode3_r <= 1'b0;
      seen_r <= 1'b0;
      wen_r <= SR_INIT[`SR_WEN];
      sleep_r <= 1'b0;
      bpl_r <= SR_INIT[`SR_BPL];
      bph_r <= SR_INIT[`SR_BPH];
      lock_r <= SR_INIT[`SR_LOCK];
    end
    else
    begin
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      sh_r <= sh_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      dptr_r <= dptr_nxt;
      srd_r <= srd_nxt;
      pvalid_r <= pvalid_nxt;
      so_r <= so_nxt;
      oe_n_r <= oe_n_nxt;
      mode3_r <= mode3_nxt;
      seen_r <= seen_nxt;
      wen_r <= wen_nxt;
      sleep_r <= sleep_nxt;
      bpl_r <= bpl_nxt;
      bph_r <= bph_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign bus.so = so_r;
  assign bus.so_oe_n = oe_n_r;

  // ----------------------------------------------------------------------
  // busy engine: walks the region one byte a clock, timer sets the length
  // ----------------------------------------------------------------------
  job_t          job_nxt;
  logic [AW-1:0] ptr_nxt, end_r, end_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic          walk_nxt;

  always_comb
  begin
    job_nxt = job_r;
    ptr_nxt = ptr_r;
    end_nxt = end_r;
    tmr_nxt = tmr_r;
    walk_nxt = walk_r;
    case (job_r)
      JOB_IDLE:
        if (start_job != JOB_IDLE)
        begin
          job_nxt = start_job;
          ptr_nxt = start_base;
          end_nxt = start_end;
          tmr_nxt = start_cyc - TW'(1);
          walk_nxt = (start_job != JOB_WRSR);
        end
      default:
      begin
        if (tmr_r != '0)
          tmr_nxt = tmr_r - TW'(1);
        if (walk_r && ptr_r == end_r)
          walk_nxt = 1'b0;
        else if (walk_r)
          ptr_nxt = ptr_r + AW'(1);
        if (tmr_r == '0 && !walk_r)
          job_nxt = JOB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      job_r <= JOB_IDLE;
      ptr_r <= '0;
      end_r <= '0;
      tmr_r <= '0;
      walk_r <= 1'b0;
    end
    else
    begin
      job_r <= job_nxt;
      ptr_r <= ptr_nxt;
      end_r <= end_nxt;
      tmr_r <= tmr_nxt;
      walk_r <= walk_nxt;
    end
  end

  // array and page buffer writes; programming only clears bits
  always_ff @(posedge clk)
  begin
    if (pb_we)
      pbuf[pb_idx] <= rx_byte;
    if (walk_r && job_r == JOB_ERASE)
      mem[ptr_r] <= 8'hFF;
    if (walk_r && job_r == JOB_PROG && pvalid_r[ptr_r[7:0]])
      mem[ptr_r] <= mem[ptr_r] & pbuf[ptr_r[7:0]];
  end

endmodule : flash_end

/* File: ctrl_end.sv */
/*
  Controller end: byte shifter in link mode 0 behind a small register port.
  Assumes software lowers select through the control register around
  each command and polls the busy bit between bytes.
*/
`timescale 1ns/1ps
`include "flash_params.svh"
module ctrl_end
  import flash_pkg::*;
#(
  parameter int HALF = `SCK_HALF
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // link pins
  spi_flash_if.ctrl       bus
);

  // slow enough for the sampling margin and far under 30 MHz
  if (HALF < 6 || HALF > 255)
  begin : g_bad_half
    $error("half period out of range");
  end

  // ----------------------------------------------------------------------
  // data-in synchroniser
  // ----------------------------------------------------------------------
  logic [2:0] ms_r;
  logic       miso_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ms_r <= 3'h7;
      miso_r <= 1'b1;
    end
    else
    begin
      ms_r <= {ms_r[1:0], bus.so_line};
      miso_r <= (ms_r[1] == ms_r[2]) ? ms_r[2] : miso_r;
    end
  end

  // ----------------------------------------------------------------------
  // registers and shifter
  // ----------------------------------------------------------------------
  hstate_t    st_r, st_nxt;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [7:0] tm_r, tm_nxt;
  logic [2:0] nb_r, nb_nxt;
  logic       sck_r, sck_nxt;
  logic       mosi_r, mosi_nxt;
  logic [7:0] rd_r, rd_nxt;

  always_comb
  begin
    st_nxt = st_r;
    ctrl_nxt = ctrl_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    tm_nxt = tm_r;
    nb_nxt = nb_r;
    sck_nxt = sck_r;
    mosi_nxt = mosi_r;
    rd_nxt = 8'h00;
    if (reg_wr && reg_addr == `H_CTRL)
      ctrl_nxt = reg_wdata[2:0];
    if (reg_rd)
    begin
      case (reg_addr)
        `H_CTRL: rd_nxt = {5'h00, ctrl_r};
        `H_RX:   rd_nxt = rx_r;
        `H_STAT: rd_nxt = {7'h00, (st_r != H_IDLE)};
        default: rd_nxt = 8'h00;
      endcase
    end
    case (st_r)
      H_IDLE:
        if (reg_wr && reg_addr == `H_TX)
        begin
          tx_nxt = reg_wdata;
          mosi_nxt = reg_wdata[7];
          nb_nxt = 3'h0;
          tm_nxt = 8'(HALF - 1);
          st_nxt = H_LOW;
        end
      H_LOW:
        if (tm_r != 8'h00)
          tm_nxt = tm_r - 8'h01;
        else
        begin
          sck_nxt = 1'b1;
          tm_nxt = 8'(HALF - 1);
          st_nxt = H_HIGH;
        end
      H_HIGH:
        if (tm_r != 8'h00)
          tm_nxt = tm_r - 8'h01;
        else
        begin
          rx_nxt = {rx_r[6:0], miso_r};
          sck_nxt = 1'b0;
          if (nb_r == 3'h7)
            st_nxt = H_IDLE;
          else
          begin
            nb_nxt = nb_r + 3'h1;
            tx_nxt = {tx_r[6:0], 1'b0};
            mosi_nxt = tx_r[6];
            tm_nxt = 8'(HALF - 1);
            st_nxt = H_LOW;
          end
        end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= H_IDLE;
      ctrl_r <= `HC_RESET;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      tm_r <= 8'h00;
      nb_r <= 3'h0;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      rd_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      ctrl_r <= ctrl_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      tm_r <= tm_nxt;
      nb_r <= nb_nxt;
      sck_r <= sck_nxt;
      mosi_r <= mosi_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign reg_rdata = rd_r;
  assign bus.cs_n = ctrl_r[0];
  assign bus.wp_n = ctrl_r[1];
  assign bus.hold_n = ctrl_r[2];
  assign bus.sck = sck_r;
  assign bus.si = mosi_r;

endmodule : ctrl_end

/* File: link_checker.sv */
/*
  Pin relations on the flash link, watched from the system clock.
  Assumes both link ends run from clk and share resetn.
*/
`timescale 1ns/1ps
module link_checker (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic hold_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // link relations; the slack of 8 covers the 3-flop pin synchroniser
  // ----
  desel_float_a: assert property (cs_n [*8] |-> so_oe_n)
    else $error("data out driven while deselected");
  hold_float_a: assert property (!hold_n [*8] |-> so_oe_n)
    else $error("data out driven during hold");
  oe_on_low_a: assert property ($fell(so_oe_n) |-> !sck)
    else $error("data out enabled while clock high");
  so_fall_a: assert property (!so_oe_n && $changed(so) |-> !sck)
    else $error("data out moved in clock high phase");
  so_steady_a: assert property (!so_oe_n && sck && $past(sck)
    |-> $stable(so))
    else $error("data out unstable while clock high");
  si_setup_a: assert property (sck |-> $stable(si))
    else $error("data in moved while clock high");
  mode_zero_a: assert property ($fell(cs_n) |-> !sck)
    else $error("select fell with clock high");
  clk_selected_a: assert property ($changed(sck) |-> !cs_n)
    else $error("link clock toggled while deselected");
endmodule : link_checker

/* File: serial_flash_command_interface_tb.sv */
/*
  Bench: controller end drives flash end through its register port.
  Assumes flash_params.svh and flash_pkg are compiled first.
*/
`timescale 1ns/1ps
`include "flash_params.svh"
module serial_flash_command_interface_tb;
  `define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
    $display("Error %0t: got %h want %h", $time, a, e); end end
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [2:0]  pins = 3'h7; // hold_n, wp_n, cs_n
  logic [15:0] r = 16'h0000; // last two received bytes
  int          mismatches = 0;
  int          checks = 0;
  spi_flash_if bus ();
  always #10 clk = ~clk;
  // short busy counts keep the run small
  flash_end #(.SSE_CYC(4096), .SE_CYC(65536), .CE_CYC(262144),
    .PP_CYC(256), .SR_CYC(16)) i_flash_end (.clk(clk), .resetn(resetn),
    .bus(bus.flash));
  ctrl_end i_ctrl_end (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus(bus.ctrl));
  link_checker i_link_checker (.clk(clk), .resetn(resetn), .cs_n(bus.cs_n),
    .sck(bus.sck), .si(bus.si), .so(bus.so), .so_oe_n(bus.so_oe_n),
    .hold_n(bus.hold_n));
  // ----
  // register port and command helpers
  // ----
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata; // data stands only in this cycle
  endtask : rd
  // settle time lets the flash synchroniser see the pins first
  task automatic pin(input logic [2:0] v);
    pins = v;
    wr(`H_CTRL, {5'h00, v});
    repeat (6) @(posedge clk);
  endtask : pin
  task automatic cmd(input int n, input logic [63:0] v);
    logic [7:0] s;
    pin({pins[2:1], 1'b0});
    for (int i = n - 1; i >= 0; i--)
    begin
      wr(`H_TX, v[8*i+:8]);
      s = 8'h01;
      for (int k = 0; k < 100 && s[0] !== 1'b0; k++)
        rd(`H_STAT, s);
      `CHK(s[0], 1'b0)
      rd(`H_RX, s);
      r = {r[7:0], s};
    end
    pin({pins[2:1], 1'b1});
  endtask : cmd
  task automatic ready;
    r = 16'h0001;
    for (int k = 0; k < 100 && r[0] !== 1'b0; k++)
      cmd(2, 64'h0500);
    `CHK(r[0], 1'b0)
  endtask : ready
  // ----
  // scenarios
  // ----
  task automatic t_basic;
    logic [7:0] d;
    rd(`H_CTRL, d);
    `CHK(d, 8'h07)
    rd(4'h2, d);
    `CHK(d, 8'h00)
    cmd(3, 64'h050000);
    `CHK(r, 16'h0000)
    cmd(1, 64'h06);
    cmd(2, 64'h0500);
    `CHK(r[7:0], 8'h02)
    cmd(3, 64'h9F0000);
    `CHK(r, 16'h5A3C)
    cmd(5, 64'hAB00000000);
    `CHK(r[7:0], 8'hC3)
    $display("basic done");
  endtask : t_basic
  task automatic t_prog;
    cmd(1, 64'h06);
    cmd(4, 64'hD7FC0ABC); // top address bits set on purpose
    cmd(2, 64'h0500);
    `CHK(r[0], 1'b1)
    ready;
    cmd(1, 64'h06);
    cmd(7, 64'h02FC00FEA55A3C); // last byte wraps inside the page
    ready;
    cmd(6, 64'h030000000000);
    `CHK(r, 16'h3CFF)
    cmd(7, 64'h0B0000FE000000);
    `CHK(r, 16'hA55A)
    cmd(6, 64'h0303FFFF0000);
    `CHK(r[7:0], 8'h3C)
    $display("prog done");
  endtask : t_prog
  task automatic t_hold;
    pin(3'b011);
    cmd(1, 64'h06);
    pin(3'b111);
    cmd(2, 64'h0500);
    `CHK(r[7:0], 8'h00)
    cmd(1, 64'h06);
    cmd(2, 64'hD700);
    cmd(2, 64'h0500);
    `CHK(r[7:0], 8'h02)
    cmd(2, 64'hFF00);
    `CHK(r[7:0], 8'hFF)
    cmd(1, 64'hB9);
    cmd(2, 64'h0500);
    `CHK(r[7:0], 8'hFF)
    cmd(1, 64'hAB);
    cmd(2, 64'h0500);
    `CHK(r[7:0], 8'h02)
    $display("hold done");
  endtask : t_hold
  task automatic t_lock;
    pin(3'b101);
    cmd(2, 64'h018C);
    cmd(2, 64'h0500);
    `CHK(r[7:0], 8'h02)
    pin(3'b111);
    cmd(2, 64'h018C);
    ready;
    `CHK(r[7:0], 8'h8C)
    pin(3'b101);
    cmd(1, 64'h06);
    cmd(2, 64'h0100);
    cmd(2, 64'h0500);
    `CHK(r[7:0], 8'h8E)
    $display("lock done");
  endtask : t_lock
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  // main sequence after 20 cycles of reset
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    t_basic;
    t_prog;
    t_hold;
    t_lock;
    end_sim;
  end
  // watchdog well beyond the expected run
  initial
  begin
    #1000000;
    mismatches++;
    end_sim;
  end
endmodule : serial_flash_command_interface_tb
